/* verilog/nmi_entry_cfg.svh */
// Constants for the non-maskable interrupt entry and return sequencer.
// How it works
// (RULE1) Acceptance clears the DMA main enable bit.
// (RULE2) Acceptance pushes the program counter onto stack.
// (RULE3) Acceptance copies primary enable flag into saved.
// (RULE4) Then primary enable flag cleared, masking interrupts.
// (RULE5) Entry ends by fetching at address 0066H.
// (RULE6) Return instruction pops the stacked program counter.
// (RULE7) Return instruction copies saved flag back to primary.
// (RULE8) Request accepted even during DMA transfers.
// (RULE9) Input falling edge latched until it is sampled.
// (RULE10) Sampled before T3/T1 of last cycle; acknowledge follows.
`ifndef NMI_ENTRY_CFG_SVH
`define NMI_ENTRY_CFG_SVH
`define NMI_VECTOR 16'h0066
`define NMI_SP_RESET 16'h0000
`define NMI_PC_RESET 16'h0000
`define NMI_ACK_CYCLES 4'h4
`endif

/* verilog/nmi_entry_pkg.sv */
// Types for the non-maskable interrupt entry sequencer.
package nmi_entry_pkg;
  typedef enum logic [2:0] {
    ST_RUN,
    ST_ACK,
    ST_PUSH_HI,
    ST_PUSH_LO,
    ST_POP_LO,
    ST_POP_HI
  } nmi_state_e;
endpackage

/* verilog/nonmaskable_interrupt_entry.sv */
// Non-maskable interrupt latch, acknowledge, entry and return sequencer.
`timescale 1ns/100ps
`include "nmi_entry_cfg.svh"
module nonmaskable_interrupt_entry (
  input wire logic clk,
  input wire logic rst,
  input wire logic nmi_n,
  input wire logic sample_point,
  input wire logic mcycle_end,
  input wire logic [15:0] cpu_pc,
  input wire logic [15:0] cpu_sp,
  input wire logic return_from_nonmaskable_exec,
  input wire logic interrupt_enable_flag_primary_set,
  input wire logic interrupt_enable_flag_primary_clr,
  input wire logic dma_main_enable_in,
  input wire logic dma_main_enable_wr,
  input wire logic mem_ready,
  input wire logic [7:0] mem_rdata,
  output logic nmi_ack,
  output logic busy,
  output logic interrupt_enable_flag_primary,
  output logic interrupt_enable_flag_saved,
  output logic dma_main_enable,
  output logic [15:0] pc_load,
  output logic pc_load_valid,
  output logic [15:0] sp_out,
  output logic mem_wr,
  output logic mem_rd,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata
);

  // ****************************************************************
  // Edge latch and sampling
  // ****************************************************************
  logic nmi_n_prev_r;
  logic nmi_pend_r;
  logic nmi_taken_r;
  nmi_entry_pkg::nmi_state_e state_r;
  logic [3:0] ack_cnt_r;
  logic [15:0] saved_pc_r;
  logic [7:0] pop_lo_r;
  logic nmi_fall;
  logic sample_hit;
  logic accept;
  logic return_from_nonmaskable_go;
  logic busy_nxt;

  assign nmi_fall = nmi_n_prev_r & ~nmi_n;
  // Sampling is not gated by DMA activity, so a transfer can be broken into. [RULE8]
  assign sample_hit = sample_point & nmi_pend_r & (state_r == nmi_entry_pkg::ST_RUN); // [RULE10]
  // Acceptance needs a sampled request and the end of the machine cycle in progress.
  assign accept = (state_r == nmi_entry_pkg::ST_RUN) && nmi_taken_r && mcycle_end; // [RULE10]
  // A return is refused in the edge where acceptance starts; acceptance wins.
  assign return_from_nonmaskable_go = (state_r == nmi_entry_pkg::ST_RUN) && return_from_nonmaskable_exec && !accept;

  always_ff @(posedge clk) begin
    if (rst) begin
      nmi_n_prev_r <= 1'b1;
    end else begin
      nmi_n_prev_r <= nmi_n;
    end
  end

  // A new edge in the sampling cycle wins over the clear, so it is never lost.
  always_ff @(posedge clk) begin
    if (rst) begin
      nmi_pend_r <= 1'b0;
    end else if (nmi_fall) begin
      nmi_pend_r <= 1'b1; // [RULE9]
    end else if (sample_hit) begin
      nmi_pend_r <= 1'b0; // [RULE9]
    end
  end

  // Sampled request waits for the current machine cycle to end.
  always_ff @(posedge clk) begin
    if (rst) begin
      nmi_taken_r <= 1'b0;
    end else if (sample_hit) begin
      nmi_taken_r <= 1'b1; // [RULE10]
    end else if (state_r == nmi_entry_pkg::ST_ACK) begin
      nmi_taken_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= nmi_entry_pkg::ST_RUN;
      ack_cnt_r <= 4'h0;
    end else begin
      case (state_r)
        nmi_entry_pkg::ST_RUN: begin
          if (nmi_taken_r && mcycle_end) begin
            state_r <= nmi_entry_pkg::ST_ACK; // [RULE10]
            ack_cnt_r <= `NMI_ACK_CYCLES - 4'h1;
          end else if (return_from_nonmaskable_exec) begin
            state_r <= nmi_entry_pkg::ST_POP_LO;
          end
        end
        nmi_entry_pkg::ST_ACK: begin
          if (ack_cnt_r == 4'h0) begin
            state_r <= nmi_entry_pkg::ST_PUSH_HI;
          end else begin
            ack_cnt_r <= ack_cnt_r - 4'h1;
          end
        end
        nmi_entry_pkg::ST_PUSH_HI: begin
          if (mem_ready) begin
            state_r <= nmi_entry_pkg::ST_PUSH_LO;
          end
        end
        nmi_entry_pkg::ST_PUSH_LO: begin
          if (mem_ready) begin
            state_r <= nmi_entry_pkg::ST_RUN;
          end
        end
        nmi_entry_pkg::ST_POP_LO: begin
          if (mem_ready) begin
            state_r <= nmi_entry_pkg::ST_POP_HI;
          end
        end
        nmi_entry_pkg::ST_POP_HI: begin
          if (mem_ready) begin
            state_r <= nmi_entry_pkg::ST_RUN;
          end
        end
        default: begin
          state_r <= nmi_entry_pkg::ST_RUN;
        end
      endcase
    end
  end

  // ****************************************************************
  // Acknowledge and busy
  // ****************************************************************
  // Busy falls at the edge that completes the last stack byte, together with
  // the jump target, so the core never sees a gap between the two.
  always_comb begin
    busy_nxt = 1'b1;
    case (state_r)
      nmi_entry_pkg::ST_RUN: begin
        busy_nxt = accept | return_from_nonmaskable_go;
      end
      nmi_entry_pkg::ST_ACK: begin
        busy_nxt = 1'b1;
      end
      nmi_entry_pkg::ST_PUSH_HI: begin
        busy_nxt = 1'b1;
      end
      nmi_entry_pkg::ST_PUSH_LO: begin
        busy_nxt = !mem_ready;
      end
      nmi_entry_pkg::ST_POP_LO: begin
        busy_nxt = 1'b1;
      end
      nmi_entry_pkg::ST_POP_HI: begin
        busy_nxt = !mem_ready;
      end
      default: begin
        busy_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      nmi_ack <= 1'b0;
      busy <= 1'b0;
    end else begin
      nmi_ack <= accept; // [RULE10]
      busy <= busy_nxt;
    end
  end

  // ****************************************************************
  // Interrupt enable flags and DMA main enable
  // ****************************************************************
  // Flags change at acknowledge start so maskable requests see the mask at once.
  always_ff @(posedge clk) begin
    if (rst) begin
      interrupt_enable_flag_primary <= 1'b0;
      interrupt_enable_flag_saved <= 1'b0;
    end else if ((state_r == nmi_entry_pkg::ST_RUN) && nmi_taken_r && mcycle_end) begin
      interrupt_enable_flag_saved <= interrupt_enable_flag_primary; // [RULE3]
      interrupt_enable_flag_primary <= 1'b0; // [RULE4]
    end else if ((state_r == nmi_entry_pkg::ST_RUN) && return_from_nonmaskable_exec) begin
      interrupt_enable_flag_primary <= interrupt_enable_flag_saved; // [RULE7]
    end else if (interrupt_enable_flag_primary_set) begin
      interrupt_enable_flag_primary <= 1'b1;
      interrupt_enable_flag_saved <= 1'b1;
    end else if (interrupt_enable_flag_primary_clr) begin
      interrupt_enable_flag_primary <= 1'b0;
      interrupt_enable_flag_saved <= 1'b0;
    end
  end

  // Acceptance overrides a software write in the same cycle.
  always_ff @(posedge clk) begin
    if (rst) begin
      dma_main_enable <= 1'b0;
    end else if ((state_r == nmi_entry_pkg::ST_RUN) && nmi_taken_r && mcycle_end) begin
      dma_main_enable <= 1'b0; // [RULE1]
    end else if (dma_main_enable_wr) begin
      dma_main_enable <= dma_main_enable_in;
    end
  end

  // ****************************************************************
  // Stack traffic and program counter
  // ****************************************************************
  // Entries are not guarded against nesting: every acceptance pushes two more
  // bytes, so requests without matching returns walk the stack down unchecked.
  always_ff @(posedge clk) begin
    if (rst) begin
      saved_pc_r <= `NMI_PC_RESET;
    end else if ((state_r == nmi_entry_pkg::ST_RUN) && nmi_taken_r && mcycle_end) begin
      saved_pc_r <= cpu_pc; // [RULE2]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pop_lo_r <= 8'h00;
    end else if ((state_r == nmi_entry_pkg::ST_POP_LO) && mem_ready) begin
      pop_lo_r <= mem_rdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sp_out <= `NMI_SP_RESET;
      mem_wr <= 1'b0;
      mem_rd <= 1'b0;
      mem_addr <= 16'h0000;
      mem_wdata <= 8'h00;
    end else begin
      mem_wr <= 1'b0;
      mem_rd <= 1'b0;
      case (state_r)
        nmi_entry_pkg::ST_RUN: begin
          sp_out <= cpu_sp;
          if (return_from_nonmaskable_exec && !(nmi_taken_r && mcycle_end)) begin
            mem_rd <= 1'b1; // [RULE6]
            mem_addr <= cpu_sp;
          end
        end
        nmi_entry_pkg::ST_ACK: begin
          if (ack_cnt_r == 4'h0) begin
            mem_wr <= 1'b1; // [RULE2]
            mem_addr <= sp_out - 16'h0001;
            mem_wdata <= saved_pc_r[15:8];
            sp_out <= sp_out - 16'h0001;
          end
        end
        nmi_entry_pkg::ST_PUSH_HI: begin
          mem_wr <= 1'b1;
          if (mem_ready) begin
            mem_addr <= sp_out - 16'h0001;
            mem_wdata <= saved_pc_r[7:0]; // [RULE2]
            sp_out <= sp_out - 16'h0001;
          end
        end
        nmi_entry_pkg::ST_PUSH_LO: begin
          mem_wr <= !mem_ready;
        end
        nmi_entry_pkg::ST_POP_LO: begin
          mem_rd <= 1'b1;
          if (mem_ready) begin
            mem_addr <= sp_out + 16'h0001;
            sp_out <= sp_out + 16'h0001;
          end
        end
        nmi_entry_pkg::ST_POP_HI: begin
          mem_rd <= !mem_ready;
          if (mem_ready) begin
            sp_out <= sp_out + 16'h0001; // [RULE6]
          end
        end
        default: begin
          sp_out <= cpu_sp;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pc_load <= 16'h0000;
      pc_load_valid <= 1'b0;
    end else begin
      pc_load_valid <= 1'b0;
      if ((state_r == nmi_entry_pkg::ST_PUSH_LO) && mem_ready) begin
        pc_load <= `NMI_VECTOR; // [RULE5]
        pc_load_valid <= 1'b1;
      end else if ((state_r == nmi_entry_pkg::ST_POP_HI) && mem_ready) begin
        pc_load <= {mem_rdata, pop_lo_r}; // [RULE6]
        pc_load_valid <= 1'b1;
      end
    end
  end

endmodule

/* test/nmi_source_model.sv */
// External source of non-maskable requests.
`timescale 1ns/100ps
module nmi_source_model #(parameter int LOW_CYCLES = 2) (
  input wire logic clk,
  input wire logic go,
  output logic nmi_n
);
  int cnt = 0;
  initial nmi_n = 1'b1;
  // The line returns high well before the next request so every fall is a fresh edge.
  always @(negedge clk) begin
    if (go) begin
      nmi_n <= 1'b0;
      cnt <= LOW_CYCLES;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else begin
      nmi_n <= 1'b1;
    end
  end
endmodule

/* test/nmi_entry_monitor.sv */
// Concurrent checks on the entry sequencer ports.
`timescale 1ns/100ps
module nmi_entry_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic mcycle_end,
  input wire logic mem_ready,
  input wire logic nmi_ack,
  input wire logic busy,
  input wire logic interrupt_enable_flag_primary,
  input wire logic interrupt_enable_flag_saved,
  input wire logic dma_main_enable,
  input wire logic [15:0] pc_load,
  input wire logic pc_load_valid,
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic [15:0] mem_addr
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_ack; nmi_ack; endsequence
  sequence s_push_hi; ##4 (mem_wr && !mem_rd); endsequence
  property p_ack_pulse; s_ack |=> !nmi_ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_cause; nmi_ack |-> $past(mcycle_end); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without cycle end");
  property p_ack_mask; s_ack |-> !interrupt_enable_flag_primary && !dma_main_enable && busy;
  endproperty
  a_ack_mask: assert property (p_ack_mask) else $error("flags not cleared");
  property p_save;
    s_ack |-> interrupt_enable_flag_saved == $past(interrupt_enable_flag_primary);
  endproperty
  a_save: assert property (p_save) else $error("saved flag wrong");
  property p_push_start; s_ack |-> s_push_hi; endproperty
  a_push_start: assert property (p_push_start) else $error("push late");
  property p_wr_hold; mem_wr && !mem_ready |=> mem_wr && $stable(mem_addr); endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write dropped");
  property p_vector;
    mem_wr && mem_ready |=> mem_wr || (pc_load_valid && pc_load == 16'h0066);
  endproperty
  a_vector: assert property (p_vector) else $error("no jump to vector");
  property p_pop_end; mem_rd && mem_ready |=> mem_rd || pc_load_valid; endproperty
  a_pop_end: assert property (p_pop_end) else $error("no return jump");
  property p_valid_pulse; pc_load_valid |=> !pc_load_valid; endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("jump pulse long");
endmodule
bind nonmaskable_interrupt_entry nmi_entry_monitor mon_u (.clk, .rst, .mcycle_end,
  .mem_ready, .nmi_ack, .busy, .interrupt_enable_flag_primary, .interrupt_enable_flag_saved,
  .dma_main_enable, .pc_load, .pc_load_valid, .mem_wr, .mem_rd, .mem_addr);

/* test/tb_nonmaskable_interrupt_entry.sv */
// Self-checking bench for the non-maskable entry sequencer.
`timescale 1ns/100ps
module tb_nonmaskable_interrupt_entry;
  logic clk = 1'b0, rst = 1'b1, go = 1'b0, nmi_n, sample_point = 1'b0, mcycle_end = 1'b0;
  logic return_from_nonmaskable_exec = 1'b0, interrupt_enable_flag_primary_set = 1'b0, interrupt_enable_flag_primary_clr = 1'b0, dma_main_enable_in = 1'b0;
  logic dma_main_enable_wr = 1'b0, mem_ready = 1'b0, nmi_ack, busy, pc_load_valid, mem_wr, mem_rd;
  logic interrupt_enable_flag_primary, interrupt_enable_flag_saved, dma_main_enable;
  logic [15:0] cpu_pc = 16'h0000, cpu_sp = 16'h8000, pc_load, sp_out, mem_addr, pc_s, sp_s;
  logic [7:0] mem_rdata = 8'h00, mem_wdata;
  logic [7:0] stk [logic [15:0]];
  logic [15:0] exp_q [$];
  logic [15:0] sp_q [$];
  integer seed = 32'h75d8;
  int n_errors = 0, checks = 0;
  nonmaskable_interrupt_entry dut_u (
    .clk(clk),
    .rst(rst),
    .nmi_n(nmi_n),
    .sample_point(sample_point),
    .mcycle_end(mcycle_end),
    .cpu_pc(cpu_pc),
    .cpu_sp(cpu_sp),
    .return_from_nonmaskable_exec(return_from_nonmaskable_exec),
    .interrupt_enable_flag_primary_set(interrupt_enable_flag_primary_set),
    .interrupt_enable_flag_primary_clr(interrupt_enable_flag_primary_clr),
    .dma_main_enable_in(dma_main_enable_in),
    .dma_main_enable_wr(dma_main_enable_wr),
    .mem_ready(mem_ready),
    .mem_rdata(mem_rdata),
    .nmi_ack(nmi_ack),
    .busy(busy),
    .interrupt_enable_flag_primary(interrupt_enable_flag_primary),
    .interrupt_enable_flag_saved(interrupt_enable_flag_saved),
    .dma_main_enable(dma_main_enable),
    .pc_load(pc_load),
    .pc_load_valid(pc_load_valid),
    .sp_out(sp_out),
    .mem_wr(mem_wr),
    .mem_rd(mem_rd),
    .mem_addr(mem_addr),
    .mem_wdata(mem_wdata)
  );
  nmi_source_model src_u (.clk(clk), .go(go), .nmi_n(nmi_n));
  always #2 clk = ~clk;
  // ****
  // Stack memory and scoreboard
  // ****
  always @(negedge clk) begin
    mem_ready <= (mem_wr | mem_rd) & 1'($random(seed));
    mem_rdata <= stk.exists(mem_addr) ? stk[mem_addr] : 8'h00;
    if (pc_load_valid === 1'b1 && exp_q.size() == 0) begin
      n_errors++;
      $display("MISMATCH pc_load expected none seen %h", pc_load);
    end else if (pc_load_valid === 1'b1) begin
      check("pc_load", pc_load, exp_q.pop_front());
      check("sp_out", sp_out, sp_q.pop_front());
    end
  end
  always @(posedge clk) if (mem_wr && mem_ready) stk[mem_addr] = mem_wdata;
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_idle;
    int n = 0;
    while ((exp_q.size() != 0 || busy !== 1'b0 || nmi_ack === 1'b1) && n < 300) begin
      @(negedge clk);
      n++;
    end
    if (n >= 300) n_errors++;
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ****
  // Entry and return with the request held in the latch
  // ****
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      cpu_pc = 16'($random(seed));
      cpu_sp = 16'($random(seed)) | 16'h8000;
      {interrupt_enable_flag_primary_set, interrupt_enable_flag_primary_clr, dma_main_enable_in, dma_main_enable_wr} = {i[0], ~i[0], 2'h3};
      @(negedge clk);
      {interrupt_enable_flag_primary_set, interrupt_enable_flag_primary_clr, dma_main_enable_wr} = 3'h0;
      go <= 1'b1;
      @(negedge clk);
      go <= 1'b0;
      // The line is already high again when sampled, so only the latch can carry it.
      repeat (4 + i) @(negedge clk);
      sample_point = 1'b1;
      @(negedge clk);
      sample_point = 1'b0;
      repeat (i) @(negedge clk);
      {mcycle_end, pc_s, sp_s} = {1'b1, cpu_pc, cpu_sp};
      exp_q.push_back(16'h0066);
      sp_q.push_back(sp_s - 16'h2);
      @(negedge clk);
      mcycle_end = 1'b0;
      for (int n = 0; n < 8 && nmi_ack !== 1'b1; n++) @(negedge clk);
      check("ack", 16'(nmi_ack), 16'h1);
      check("dme", 16'(dma_main_enable), 16'h0);
      check("interrupt_enable_flag_primary", 16'(interrupt_enable_flag_primary), 16'h0);
      check("interrupt_enable_flag_saved", 16'(interrupt_enable_flag_saved), 16'(i[0]));
      cpu_sp = sp_s - 16'h2;
      wait_idle();
      check("stack hi", 16'(stk[sp_s - 16'h1]), 16'(pc_s[15:8]));
      check("stack lo", 16'(stk[sp_s - 16'h2]), 16'(pc_s[7:0]));
      exp_q.push_back(pc_s);
      sp_q.push_back(sp_s);
      return_from_nonmaskable_exec = 1'b1;
      @(negedge clk);
      return_from_nonmaskable_exec = 1'b0;
      wait_idle();
      check("interrupt_enable_flag_primary back", 16'(interrupt_enable_flag_primary), 16'(i[0]));
      cpu_sp = sp_s;
      $display("test %0d done", i);
    end
    finish_test();
  end
  initial begin
    #(4 * 4000);
    n_errors++;
    finish_test();
  end
endmodule
